// file: pkg/pcit_defs.vh
/*
 * Constants for the current, input and temperature status flag bank.
 * Assumes inclusion by bare name from the rtl files; definitions only.
 */
`ifndef PCIT_DEFS_VH
`define PCIT_DEFS_VH

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define PCIT_CMD_IOUT        8'h7B
`define PCIT_CMD_INPUT       8'h7C
`define PCIT_CMD_TEMP        8'h7D

// ----------------------------------------------------------------------
// page selections
// ----------------------------------------------------------------------
`define PCIT_PAGE_A          8'h00
`define PCIT_PAGE_B          8'h01
`define PCIT_PAGE_ALL        8'hFF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PCIT_OUT_OC_FAULT_BIT 7
`define PCIT_OUT_OC_WARN_BIT 5
`define PCIT_OUT_SHARE_BIT   3
`define PCIT_IN_OVF_BIT      7
`define PCIT_IN_UVF_BIT      4
`define PCIT_IN_LOW_BIT      3
`define PCIT_IN_OCF_BIT      2
`define PCIT_IN_OCW_BIT      1
`define PCIT_IN_OPW_BIT      0
`define PCIT_TEMP_FAULT_BIT  7
`define PCIT_TEMP_WARN_BIT   6

// ----------------------------------------------------------------------
// supported-bit masks and reset values
// ----------------------------------------------------------------------
`define PCIT_IOUT_MASK       8'hA8
`define PCIT_INPUT_MASK      8'h9F
`define PCIT_TEMP_MASK       8'hC0
`define PCIT_FLAGS_RESET     8'h00

`endif

// file: rtl/pcit_flag_latch.v
/*
 * One status byte of sticky flags with write-one-to-clear.
 * Assumes events are single-clock-domain pulses or levels on i_clk_sys.
 */
`timescale 1ns/100ps
`include "pcit_defs.vh"

module pcit_flag_latch #(
  parameter [7:0] MASK = 8'hFF
) (
  input  wire       i_clk_sys,
  input  wire       i_reset,
  input  wire [7:0] i_set,
  input  wire       i_clr_en,
  input  wire [7:0] i_clr_data,
  output wire [7:0] o_flags
);

  reg  [7:0] flags_ff;
  wire [7:0] nxt_flags;
  wire [7:0] clr_bits;

  // only supported bits may be cleared or held
  assign clr_bits  = i_clr_en ? (i_clr_data & MASK) : 8'h00;
  // set wins over a clear in the same cycle; held until cleared
  assign nxt_flags = ((flags_ff & ~clr_bits) | i_set) & MASK;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      flags_ff <= `PCIT_FLAGS_RESET;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign o_flags = flags_ff;

endmodule

// file: rtl/pcit_status_bank.v
/*
 * Status flag bank for a dual-channel power module: output-current and
 * temperature flags per channel, one input flag byte for both.
 * Assumes a command decoder on i_clk_sys gives one-cycle read and write
 * strobes with command code, page and data; condition inputs are on the
 * same clock (already filtered by the detection logic).
 */
`timescale 1ns/100ps
`include "pcit_defs.vh"

module pcit_status_bank (
  input  wire       i_clk_sys,
  input  wire       i_reset,
  input  wire       i_wr_stb,
  input  wire       i_rd_stb,
  input  wire [7:0] i_cmd,
  input  wire [7:0] i_page,
  input  wire [7:0] i_wr_data,
  input  wire [1:0] i_out_overcurrent_fault,
  input  wire [1:0] i_out_overcurrent_warning,
  input  wire [1:0] i_phase_sharing_fault,
  input  wire [1:0] i_overtemp_fault,
  input  wire [1:0] i_overtemp_warning,
  input  wire       i_input_overvoltage_fault,
  input  wire       i_input_undervoltage_fault,
  input  wire       i_input_too_low_off,
  input  wire       i_input_overcurrent_fault,
  input  wire       i_input_overcurrent_warning,
  input  wire       i_input_overpower_warning,
  output reg  [7:0] o_rd_data,
  output reg        o_rd_valid,
  output reg        o_rd_hit,
  output wire [7:0] o_iout_flags_a,
  output wire [7:0] o_iout_flags_b,
  output wire [7:0] o_input_flags,
  output wire [7:0] o_temp_flags_a,
  output wire [7:0] o_temp_flags_b
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  // channel 0 = A; FFh and any other page fall to A
  function sel_b;
    input [7:0] page;
    begin
      sel_b = (page == `PCIT_PAGE_B);
    end
  endfunction

  function is_cmd;
    input [7:0] cmd;
    input [7:0] code;
    begin
      is_cmd = (cmd == code);
    end
  endfunction

  wire        page_b;
  wire [7:0]  iout_q [0:1];
  wire [7:0]  temp_q [0:1];
  wire [7:0]  input_set;
  wire        wr_input;

  assign page_b = sel_b(i_page);

  // ----------------------------------------------------------------------
  // per-channel paged flag bytes
  // ----------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
      wire [7:0] iout_set;
      wire [7:0] temp_set;
      wire       wr_here;
      wire       wr_iout;
      wire       wr_temp;

      assign iout_set = {i_out_overcurrent_fault[ch],
                         1'b0,
                         i_out_overcurrent_warning[ch],
                         1'b0,
                         i_phase_sharing_fault[ch],
                         3'b000};
      assign temp_set = {i_overtemp_fault[ch],
                         i_overtemp_warning[ch],
                         6'h00};
      // writes with page FFh land on channel A only
      assign wr_here = (ch == 1) ? page_b : ~page_b;
      assign wr_iout = i_wr_stb & wr_here &
                       is_cmd(i_cmd, `PCIT_CMD_IOUT);
      assign wr_temp = i_wr_stb & wr_here &
                       is_cmd(i_cmd, `PCIT_CMD_TEMP);

      pcit_flag_latch #(
        .MASK (`PCIT_IOUT_MASK)
      ) u_iout (
        .i_clk_sys  (i_clk_sys),
        .i_reset    (i_reset),
        .i_set      (iout_set),
        .i_clr_en   (wr_iout),
        .i_clr_data (i_wr_data),
        .o_flags    (iout_q[ch])
      );

      pcit_flag_latch #(
        .MASK (`PCIT_TEMP_MASK)
      ) u_temp (
        .i_clk_sys  (i_clk_sys),
        .i_reset    (i_reset),
        .i_set      (temp_set),
        .i_clr_en   (wr_temp),
        .i_clr_data (i_wr_data),
        .o_flags    (temp_q[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // shared input flag byte
  // ----------------------------------------------------------------------
  assign input_set = {i_input_overvoltage_fault,
                      2'b00,
                      i_input_undervoltage_fault,
                      i_input_too_low_off,
                      i_input_overcurrent_fault,
                      i_input_overcurrent_warning,
                      i_input_overpower_warning};
  // page deliberately not decoded here
  assign wr_input = i_wr_stb & is_cmd(i_cmd, `PCIT_CMD_INPUT);

  pcit_flag_latch #(
    .MASK (`PCIT_INPUT_MASK)
  ) u_input (
    .i_clk_sys  (i_clk_sys),
    .i_reset    (i_reset),
    .i_set      (input_set),
    .i_clr_en   (wr_input),
    .i_clr_data (i_wr_data),
    .o_flags    (o_input_flags)
  );

  // ----------------------------------------------------------------------
  // read return, one cycle after the strobe
  // ----------------------------------------------------------------------
  reg [7:0] nxt_rd_data;
  reg       nxt_rd_hit;

  always @* begin
    nxt_rd_data = 8'h00;
    nxt_rd_hit  = 1'b1;
    case (i_cmd)
      `PCIT_CMD_IOUT:  nxt_rd_data = page_b ? iout_q[1] : iout_q[0];
      `PCIT_CMD_INPUT: nxt_rd_data = o_input_flags;
      `PCIT_CMD_TEMP:  nxt_rd_data = page_b ? temp_q[1] : temp_q[0];
      default:         nxt_rd_hit  = 1'b0;
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
      o_rd_hit   <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_stb;
      if (i_rd_stb) begin
        o_rd_data <= nxt_rd_data;
        o_rd_hit  <= nxt_rd_hit;
      end
    end
  end

  assign o_iout_flags_a = iout_q[0];
  assign o_iout_flags_b = iout_q[1];
  assign o_temp_flags_a = temp_q[0];
  assign o_temp_flags_b = temp_q[1];

endmodule

// file: tb/pcit_host.sv
/* host model: single-byte reads and writes to the flag bank.
   assumes the caller steps it on the falling clock edge. */
`timescale 1ns/100ps
module pcit_host (
  input  wire        i_clk_sys,
  output logic       o_wr_stb,
  output logic       o_rd_stb,
  output logic [7:0] o_cmd,
  output logic [7:0] o_page,
  output logic [7:0] o_wr_data
);
  initial {o_wr_stb, o_rd_stb, o_cmd, o_page, o_wr_data} = '0;
  // one byte per transfer, page rides along
  task automatic xfer(input logic w, input logic [7:0] c, p, d);
    @(negedge i_clk_sys);
    {o_wr_stb, o_rd_stb, o_cmd, o_page, o_wr_data} = {w, !w, c, p, d};
    @(negedge i_clk_sys);
    {o_wr_stb, o_rd_stb} = 2'b00;
    // released data must not keep its old value
    o_wr_data = ~d;
  endtask
endmodule

// file: tb/pcit_status_bank_asserts.sv
/* checker for the status flag bank.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module pcit_status_bank_asserts (
  input wire logic       i_clk_sys,
  input wire logic       i_reset,
  input wire logic       i_wr_stb,
  input wire logic       i_rd_stb,
  input wire logic [7:0] i_cmd,
  input wire logic [7:0] i_page,
  input wire logic [7:0] i_wr_data,
  input wire logic [1:0] i_out_overcurrent_fault,
  input wire logic [1:0] i_out_overcurrent_warning,
  input wire logic [1:0] i_phase_sharing_fault,
  input wire logic       i_input_overvoltage_fault,
  input wire logic       i_input_undervoltage_fault,
  input wire logic       o_rd_valid,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_iout_flags_a,
  input wire logic [7:0] o_iout_flags_b,
  input wire logic [7:0] o_input_flags,
  input wire logic [7:0] o_temp_flags_a,
  input wire logic [7:0] o_temp_flags_b
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_ocf; i_out_overcurrent_fault[0] |=> o_iout_flags_a[7]; endproperty
  a_ocf: assert property (p_ocf)
    else $error("ocf not latched");
  property p_ocw; i_out_overcurrent_warning[1] |=> o_iout_flags_b[5];
  endproperty
  a_ocw: assert property (p_ocw)
    else $error("ocw not latched");
  property p_shr; i_phase_sharing_fault[0] |=> o_iout_flags_a[3]; endproperty
  a_shr: assert property (p_shr)
    else $error("share not latched");
  property p_uvf; i_input_undervoltage_fault |=> o_input_flags[4]; endproperty
  a_uvf: assert property (p_uvf)
    else $error("uvf not latched");
  property p_zero; ((o_iout_flags_a | o_iout_flags_b) & 8'h57) == 8'h00 &&
    (o_input_flags & 8'h60) == 8'h00 &&
    ((o_temp_flags_a | o_temp_flags_b) & 8'h3F) == 8'h00; endproperty
  a_zero: assert property (p_zero)
    else $error("reserved bit set");
  property p_clr; i_wr_stb && i_cmd == 8'h7C && i_wr_data[7] &&
    !i_input_overvoltage_fault |=> !o_input_flags[7]; endproperty
  a_clr: assert property (p_clr)
    else $error("ovf not cleared");
  property p_hold; o_input_flags[4] && !(i_wr_stb && i_cmd == 8'h7C &&
    i_wr_data[4]) |=> o_input_flags[4]; endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped");
  property p_pgff; i_rd_stb && i_cmd == 8'h7D && i_page == 8'hFF |=>
    o_rd_valid && o_rd_data == $past(o_temp_flags_a); endproperty
  a_pgff: assert property (p_pgff)
    else $error("page ff read");
endmodule
bind pcit_status_bank pcit_status_bank_asserts u_chk (.*);

// file: tb/tb_pcit_status_bank.sv
/* self-checking bench for the status flag bank.
   assumes the host model and checker are compiled first. */
`timescale 1ns/100ps
module tb_pcit_status_bank;
  logic        i_clk_sys = 1'b0;
  logic        i_reset   = 1'b1;
  logic [15:0] cnd = '0;
  wire         wr, rd, vld, hit;
  wire  [7:0]  cmd, page, wd, rdat, ioa, iob, inp, tpa, tpb;
  logic [7:0]  io[2], tp[2], ip;
  logic [7:0]  cl[4] = '{8'h7B, 8'h7C, 8'h7D, 8'h7E};
  logic [7:0]  pl[4] = '{8'h00, 8'h01, 8'hFF, 8'h02};
  logic [39:0] q[$];
  int          error_cnt = 0;
  int          checks = 0;
  initial forever #2 i_clk_sys = ~i_clk_sys;
  pcit_host host (.i_clk_sys, .o_wr_stb(wr), .o_rd_stb(rd), .o_cmd(cmd),
    .o_page(page), .o_wr_data(wd));
  pcit_status_bank dut (.i_clk_sys, .i_reset, .i_wr_stb(wr), .i_rd_stb(rd),
    .i_cmd(cmd), .i_page(page), .i_wr_data(wd),
    .i_out_overcurrent_fault(cnd[1:0]), .i_out_overcurrent_warning(cnd[3:2]),
    .i_phase_sharing_fault(cnd[5:4]), .i_overtemp_fault(cnd[7:6]),
    .i_overtemp_warning(cnd[9:8]), .i_input_overvoltage_fault(cnd[15]),
    .i_input_undervoltage_fault(cnd[14]), .i_input_too_low_off(cnd[13]),
    .i_input_overcurrent_fault(cnd[12]), .i_input_overcurrent_warning(cnd[11]),
    .i_input_overpower_warning(cnd[10]), .o_rd_data(rdat), .o_rd_valid(vld),
    .o_rd_hit(hit), .o_iout_flags_a(ioa), .o_iout_flags_b(iob),
    .o_input_flags(inp), .o_temp_flags_a(tpa), .o_temp_flags_b(tpb));
  task automatic chk(input logic [39:0] g, e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // shadow of the flags: reads are predicted, writes clear supported ones
  task automatic op(input logic w, input logic [7:0] c, p, d);
    int ch;
    ch = (p == 8'h01);
    if (!w) q.push_back(c == 8'h7B ? {31'h1, io[ch]} : c == 8'h7C ?
      {31'h1, ip} : c == 8'h7D ? {31'h1, tp[ch]} : 40'h0);
    else if (c == 8'h7B) io[ch] &= ~(d & 8'hA8);
    else if (c == 8'h7C) ip &= ~(d & 8'h9F);
    else if (c == 8'h7D) tp[ch] &= ~(d & 8'hC0);
    host.xfer(w, c, p, d);
  endtask
  task automatic pulse;
    @(negedge i_clk_sys);
    cnd = 16'($urandom & $urandom & $urandom);
    for (int c = 0; c < 2; c++) begin
      io[c] |= {cnd[c], 1'b0, cnd[2+c], 1'b0, cnd[4+c], 3'b0};
      tp[c] |= {cnd[6+c], cnd[8+c], 6'b0};
    end
    ip |= {cnd[15], 2'b0, cnd[14:10]};
    @(negedge i_clk_sys);
    cnd = '0;
  endtask
  always @(negedge i_clk_sys) if (vld === 1'b1)
    chk({hit, rdat}, q.size() ? q.pop_front() : '1);
  initial begin
    void'($urandom(32'h4939));
    {io[0], io[1], tp[0], tp[1], ip} = '0;
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys) i_reset = 1'b0;
    for (int i = 0; i < 16; i++) op(0, cl[i%4], pl[i/4], 8'h00);
    $display("reset read test done");
    for (int i = 0; i < 400; i++) begin
      pulse();
      op(1, cl[$urandom%4], pl[$urandom%4], 8'($urandom));
      op(0, cl[$urandom%4], pl[$urandom%4], 8'h00);
      chk({ioa, iob, inp, tpa, tpb},
          {io[0], io[1], ip, tp[0], tp[1]});
    end
    $display("random set and clear test done");
    repeat (3) @(negedge i_clk_sys);
    if (q.size() != 0) error_cnt++;
    report_and_stop();
  end
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule
